// ### core/grp_regs.sv
// general register pointer and program status word, top level
`timescale 1ns/1ps
module grp_regs (
  // clock and resets
  input wire logic core_clk_in,
  input wire logic rst_in,
  input wire logic wdt_reset_in,
  input wire logic ce_reset_in,
  // system register port
  input wire logic [6:0] sys_addr_in,
  input wire logic sys_wr_in,
  input wire logic sys_rd_in,
  input wire logic [3:0] sys_wdata_in,
  output logic [3:0] sys_rdata_out,
  output logic sys_hit_out,
  // instruction addressing
  input wire logic [grp_pkg::COL_W-1:0] gr_col_in,
  input wire logic [grp_pkg::DM_ADDR_W-1:0] mem_addr_in,
  input wire logic [grp_pkg::DM_ADDR_W-1:0] index_in,
  input wire logic index_applies_in,
  output logic [grp_pkg::DM_ADDR_W-1:0] gr_addr_out,
  output logic [grp_pkg::DM_ADDR_W-1:0] mem_real_addr_out,
  // arithmetic request
  input wire logic arith_valid_in,
  input wire logic [1:0] arith_op_in,
  input wire logic [3:0] arith_gr_data_in,
  input wire logic [3:0] arith_mem_data_in,
  input wire logic arith_dest_sys_in,
  input wire logic [6:0] arith_dest_addr_in,
  output logic [3:0] arith_result_out,
  output logic arith_store_out,
  // pointer and flag view
  output logic [grp_pkg::PTR_W-1:0] genreg_pointer_out,
  output logic [4:0] alu_status_word_out,
  output logic decimal_flag_out,
  output logic compare_only_flag_out,
  output logic carry_flag_out,
  output logic zero_flag_out,
  output logic index_enable_flag_out
);

  // the three nibbles
  logic [3:0] pointer_bank_nibble_reg;
  logic [3:0] pointer_bank_nibble_next;
  logic [3:0] pointer_row_nibble_reg;
  logic [3:0] pointer_row_nibble_next;
  logic [3:0] flag_nibble_reg;
  logic [3:0] flag_nibble_next;
  // registered outputs
  logic [3:0] sys_rdata_reg;
  logic sys_hit_reg;
  logic [grp_pkg::DM_ADDR_W-1:0] gr_addr_reg;
  logic [grp_pkg::DM_ADDR_W-1:0] real_addr_reg;
  logic [3:0] arith_result_reg;
  logic arith_store_reg;

  // address and arithmetic units share one bundle
  grp_core_if core_bus ();

  // any of the three reset causes clears all nibbles
  wire any_reset = rst_in | wdt_reset_in | ce_reset_in;

  // the decimal flag lives in the row nibble, not the flag nibble
  wire decimal_flag = pointer_row_nibble_reg[grp_pkg::ROW_DECIMAL_BIT];

  // named views of the flag nibble
  wire compare_only_flag = flag_nibble_reg[grp_pkg::FLAG_CMP_BIT];
  wire carry_flag = flag_nibble_reg[grp_pkg::FLAG_CARRY_BIT];
  wire zero_flag = flag_nibble_reg[grp_pkg::FLAG_ZERO_BIT];
  wire index_enable_flag = flag_nibble_reg[grp_pkg::FLAG_IXE_BIT];
  // five-bit status word in the documented order
  wire [4:0] alu_status_word = {decimal_flag, flag_nibble_reg};
  // seven-bit pointer, decimal bit excluded
  wire [grp_pkg::PTR_W-1:0] genreg_pointer =
    {pointer_bank_nibble_reg, pointer_row_nibble_reg[grp_pkg::ROW_MSB:grp_pkg::ROW_LSB]};

  // nibble decode for the system port; the arithmetic destination compares its own address
  function automatic logic nib_hit(input logic [6:0] addr, input logic [6:0] target);
    nib_hit = (addr == target);
  endfunction

  // system port address decode
  wire sel_bank = nib_hit(sys_addr_in, grp_pkg::ADDR_PTR_BANK);
  wire sel_row = nib_hit(sys_addr_in, grp_pkg::ADDR_PTR_ROW);
  wire sel_flags = nib_hit(sys_addr_in, grp_pkg::ADDR_FLAGS);
  wire sys_sel = sel_bank | sel_row | sel_flags;
  wire wr_bank = sys_wr_in & sel_bank;
  wire wr_row = sys_wr_in & sel_row;
  wire wr_flags = sys_wr_in & sel_flags;

  // read data mux, unmapped addresses read zero
  wire [3:0] sys_read_mux = sel_bank ? pointer_bank_nibble_reg :
                            sel_row ? pointer_row_nibble_reg :
                            sel_flags ? flag_nibble_reg : grp_pkg::NIB_ZERO;

  // address unit hookup
  assign core_bus.pointer = genreg_pointer;
  assign core_bus.gr_col = gr_col_in;
  assign core_bus.mem_addr = mem_addr_in;
  assign core_bus.index_val = index_in;
  assign core_bus.index_enable = index_enable_flag;
  assign core_bus.index_applies = index_applies_in;

  grp_addr_gen u_addr_gen (
    .bus(core_bus.addr_unit)
  );

  // operation code decode
  function automatic logic op_is_sub(input logic [1:0] op);
    op_is_sub = (op == grp_pkg::OP_SUB) | (op == grp_pkg::OP_SUBC);
  endfunction

  function automatic logic op_is_chain(input logic [1:0] op);
    op_is_chain = (op == grp_pkg::OP_ADDC) | (op == grp_pkg::OP_SUBC);
  endfunction

  // arithmetic decode
  wire op_sub = op_is_sub(arith_op_in);
  wire op_chain = op_is_chain(arith_op_in);
  // the register operand pairs with the memory operand in one step
  assign core_bus.op_a = arith_gr_data_in;
  assign core_bus.op_b = arith_mem_data_in;
  assign core_bus.carry_in = op_chain & carry_flag;
  assign core_bus.subtract = op_sub;
  assign core_bus.decimal = decimal_flag;

  grp_arith u_arith (
    .bus(core_bus.arith_unit)
  );

  // arithmetic unit answers
  wire [3:0] arith_res = core_bus.result;
  wire arith_cout = core_bus.carry_out;
  wire res_zero = (arith_res == grp_pkg::NIB_ZERO);

  // compare-only mode suppresses the store of the result
  wire arith_stores = arith_valid_in & ~compare_only_flag;
  // result aimed at one of our own nibbles
  wire dest_bank = arith_stores & arith_dest_sys_in &
                   (arith_dest_addr_in == grp_pkg::ADDR_PTR_BANK);
  wire dest_row = arith_stores & arith_dest_sys_in &
                  (arith_dest_addr_in == grp_pkg::ADDR_PTR_ROW);
  wire dest_flags = arith_stores & arith_dest_sys_in &
                    (arith_dest_addr_in == grp_pkg::ADDR_FLAGS);

  // zero rule: in compare mode zero only survives while every step is zero
  function automatic logic zero_update(input logic cmp_mode, input logic old_zero,
                                       input logic now_zero);
    zero_update = cmp_mode ? (old_zero & now_zero) : now_zero;
  endfunction

  // flag values after an arithmetic step; compare and index enable are kept
  wire carry_after = arith_cout;
  wire zero_after = zero_update(compare_only_flag, zero_flag, res_zero);
  wire [3:0] flags_from_alu = {compare_only_flag, carry_after, zero_after, index_enable_flag};

  // next value of the bank nibble
  always_comb begin
    pointer_bank_nibble_next = pointer_bank_nibble_reg;
    if (wr_bank) begin
      pointer_bank_nibble_next = sys_wdata_in;
    end else if (dest_bank) begin
      pointer_bank_nibble_next = arith_res;
    end
  end

  // next value of the row nibble, decimal flag rides along
  // hazard: a pointer write also moves the decimal mode, software must set bit 0
  always_comb begin
    pointer_row_nibble_next = pointer_row_nibble_reg;
    if (wr_row) begin
      pointer_row_nibble_next = sys_wdata_in;
    end else if (dest_row) begin
      pointer_row_nibble_next = arith_res;
    end
  end

  // next flags: port write first, then stored result, then flag update
  always_comb begin
    flag_nibble_next = flag_nibble_reg;
    if (wr_flags) begin
      flag_nibble_next = sys_wdata_in;
    end else if (dest_flags) begin
      flag_nibble_next = arith_res;
    end else if (arith_valid_in) begin
      flag_nibble_next = flags_from_alu;
    end
  end

  // bank nibble; no gating here, a stopped clock gives no edges and the value stays
  always_ff @(posedge core_clk_in) begin
    if (any_reset) begin
      pointer_bank_nibble_reg <= grp_pkg::RST_PTR_BANK;
    end else begin
      pointer_bank_nibble_reg <= pointer_bank_nibble_next;
    end
  end

  // row nibble with the decimal flag
  always_ff @(posedge core_clk_in) begin
    if (any_reset) begin
      pointer_row_nibble_reg <= grp_pkg::RST_PTR_ROW;
    end else begin
      pointer_row_nibble_reg <= pointer_row_nibble_next;
    end
  end

  // flag nibble
  always_ff @(posedge core_clk_in) begin
    if (any_reset) begin
      flag_nibble_reg <= grp_pkg::RST_FLAGS;
    end else begin
      flag_nibble_reg <= flag_nibble_next;
    end
  end

  // registered read data, one cycle after the read strobe, held between reads
  always_ff @(posedge core_clk_in) begin
    if (rst_in) begin
      sys_rdata_reg <= grp_pkg::NIB_ZERO;
    end else begin
      sys_rdata_reg <= sys_rd_in ? sys_read_mux : sys_rdata_reg;
    end
  end

  // hit flag stands for one cycle after a read of a mapped nibble
  always_ff @(posedge core_clk_in) begin
    if (rst_in) begin
      sys_hit_reg <= 1'b0;
    end else begin
      sys_hit_reg <= sys_rd_in & sys_sel;
    end
  end

  // registered general register address; sixteen columns of one row
  always_ff @(posedge core_clk_in) begin
    if (rst_in) begin
      gr_addr_reg <= '0;
    end else begin
      gr_addr_reg <= core_bus.gr_addr;
    end
  end

  // registered real address after index modification
  always_ff @(posedge core_clk_in) begin
    if (rst_in) begin
      real_addr_reg <= '0;
    end else begin
      real_addr_reg <= core_bus.real_addr;
    end
  end

  // result is held so the memory write path can take it late
  always_ff @(posedge core_clk_in) begin
    if (rst_in) begin
      arith_result_reg <= grp_pkg::NIB_ZERO;
    end else begin
      arith_result_reg <= arith_valid_in ? arith_res : arith_result_reg;
    end
  end

  // store strobe stands one cycle per executed step outside compare-only mode
  always_ff @(posedge core_clk_in) begin
    if (rst_in) begin
      arith_store_reg <= 1'b0;
    end else begin
      arith_store_reg <= arith_stores;
    end
  end

  // registered outputs
  assign sys_rdata_out = sys_rdata_reg;
  assign sys_hit_out = sys_hit_reg;
  assign gr_addr_out = gr_addr_reg;
  assign mem_real_addr_out = real_addr_reg;
  assign arith_result_out = arith_result_reg;
  assign arith_store_out = arith_store_reg;

  // live views straight from the nibbles, no extra cycle
  assign genreg_pointer_out = genreg_pointer;
  assign alu_status_word_out = alu_status_word;
  assign decimal_flag_out = decimal_flag;
  assign compare_only_flag_out = compare_only_flag;
  assign carry_flag_out = carry_flag;
  assign zero_flag_out = zero_flag;
  assign index_enable_flag_out = index_enable_flag;

endmodule // grp_regs

// ### core/grp_pkg.sv
// constants for the general register pointer and status word block
package grp_pkg;
  // system register addresses of the three nibbles
  localparam logic [6:0] ADDR_PTR_BANK = 7'h7d;
  localparam logic [6:0] ADDR_PTR_ROW = 7'h7e;
  localparam logic [6:0] ADDR_FLAGS = 7'h7f;
  // values after any reset
  localparam logic [3:0] RST_PTR_BANK = 4'h0;
  localparam logic [3:0] RST_PTR_ROW = 4'h0;
  localparam logic [3:0] RST_FLAGS = 4'h0;
  // field positions
  localparam int ROW_DECIMAL_BIT = 0;
  localparam int ROW_MSB = 3;
  localparam int ROW_LSB = 1;
  localparam int FLAG_CMP_BIT = 3;
  localparam int FLAG_CARRY_BIT = 2;
  localparam int FLAG_ZERO_BIT = 1;
  localparam int FLAG_IXE_BIT = 0;
  // widths of the data memory address
  localparam int BANK_W = 4;
  localparam int ROW_W = 3;
  localparam int COL_W = 4;
  localparam int DM_ADDR_W = BANK_W + ROW_W + COL_W;
  localparam int PTR_W = BANK_W + ROW_W;
  // decimal adjustment constants
  localparam logic [4:0] BCD_LIMIT = 5'h09;
  localparam logic [4:0] BCD_CORR = 5'h06;
  localparam logic [3:0] NIB_ZERO = 4'h0;
  // arithmetic instruction codes
  localparam logic [1:0] OP_ADD = 2'h0;
  localparam logic [1:0] OP_ADDC = 2'h1;
  localparam logic [1:0] OP_SUB = 2'h2;
  localparam logic [1:0] OP_SUBC = 2'h3;
endpackage

// ### core/grp_core_if.sv
// bundles between the top and its address and arithmetic units
`timescale 1ns/1ps
interface grp_core_if;
  // address generation group
  logic [grp_pkg::PTR_W-1:0] pointer;
  logic [grp_pkg::COL_W-1:0] gr_col;
  logic [grp_pkg::DM_ADDR_W-1:0] mem_addr;
  logic [grp_pkg::DM_ADDR_W-1:0] index_val;
  logic index_enable;
  logic index_applies;
  logic [grp_pkg::DM_ADDR_W-1:0] gr_addr;
  logic [grp_pkg::DM_ADDR_W-1:0] real_addr;
  // arithmetic group
  logic [3:0] op_a;
  logic [3:0] op_b;
  logic carry_in;
  logic subtract;
  logic decimal;
  logic [3:0] result;
  logic carry_out;

  modport top_addr (output pointer, gr_col, mem_addr, index_val, index_enable, index_applies,
                    input gr_addr, real_addr);
  modport addr_unit (input pointer, gr_col, mem_addr, index_val, index_enable, index_applies,
                     output gr_addr, real_addr);
  modport top_arith (output op_a, op_b, carry_in, subtract, decimal, input result, carry_out);
  modport arith_unit (input op_a, op_b, carry_in, subtract, decimal, output result, carry_out);
endinterface

// ### core/grp_addr_gen.sv
// general register and real data memory address generation
`timescale 1ns/1ps
module grp_addr_gen (
  grp_core_if.addr_unit bus
);
  // bank and row from the pointer, column from the operand
  assign bus.gr_addr = {bus.pointer, bus.gr_col};
  // index ORs into bank, row and column only while enabled
  wire idx_on = bus.index_enable & bus.index_applies;
  assign bus.real_addr = idx_on ? (bus.mem_addr | bus.index_val) : bus.mem_addr;
endmodule // grp_addr_gen

// ### core/grp_arith.sv
// four-bit add and subtract with optional decimal adjustment
`timescale 1ns/1ps
module grp_arith (
  grp_core_if.arith_unit bus
);
  // binary sum or difference, bit 4 is carry or borrow
  function automatic logic [4:0] bin_op(input logic [3:0] a, input logic [3:0] b,
                                        input logic c, input logic sub);
    bin_op = sub ? ({1'b0, a} - {1'b0, b} - {4'h0, c}) : ({1'b0, a} + {1'b0, b} + {4'h0, c});
  endfunction

  wire [4:0] raw = bin_op(bus.op_a, bus.op_b, bus.carry_in, bus.subtract);
  // decimal add: over nine corrects by six and carries
  wire add_fix = (raw > grp_pkg::BCD_LIMIT);
  wire [4:0] add_dec = raw + grp_pkg::BCD_CORR;
  // decimal subtract: a borrow takes six off the low nibble
  wire [4:0] sub_dec = raw - grp_pkg::BCD_CORR;

  // binary result unless the decimal flag is set
  assign bus.result = !bus.decimal ? raw[3:0] :
                      bus.subtract ? (raw[4] ? sub_dec[3:0] : raw[3:0]) :
                      (add_fix ? add_dec[3:0] : raw[3:0]);
  assign bus.carry_out = (bus.decimal && !bus.subtract) ? add_fix : raw[4];
endmodule // grp_arith

// ### verification/grp_regs_props.sv
// concurrent checks on the pointer and status word top-level ports
`timescale 1ns/1ps
module grp_regs_props (
  // clock and resets
  input wire logic core_clk_in,
  input wire logic rst_in,
  input wire logic wdt_reset_in,
  input wire logic ce_reset_in,
  // system register port
  input wire logic [6:0] sys_addr_in,
  input wire logic sys_wr_in,
  input wire logic sys_rd_in,
  input wire logic [3:0] sys_wdata_in,
  input wire logic [3:0] sys_rdata_out,
  input wire logic sys_hit_out,
  // addressing
  input wire logic [3:0] gr_col_in,
  input wire logic [10:0] mem_addr_in,
  input wire logic [10:0] index_in,
  input wire logic index_applies_in,
  input wire logic [10:0] gr_addr_out,
  input wire logic [10:0] mem_real_addr_out,
  // arithmetic and status
  input wire logic arith_valid_in,
  input wire logic arith_dest_sys_in,
  input wire logic [6:0] arith_dest_addr_in,
  input wire logic [3:0] arith_result_out,
  input wire logic arith_store_out,
  input wire logic [6:0] genreg_pointer_out,
  input wire logic [4:0] alu_status_word_out
);
  default clocking cb @(posedge core_clk_in); endclocking
  default disable iff (rst_in);
  // soft resets win over writes, so write checks skip those edges
  wire logic quiet = !wdt_reset_in && !ce_reset_in;
  flag_write_a: assert property (sys_wr_in && sys_addr_in == 7'h7f && quiet |=>
    alu_status_word_out[3:0] == $past(sys_wdata_in)) else $error("flag nibble write lost");
  bank_write_a: assert property (sys_wr_in && sys_addr_in == 7'h7d && quiet |=>
    genreg_pointer_out[6:3] == $past(sys_wdata_in)) else $error("bank nibble write lost");
  row_write_a: assert property (sys_wr_in && sys_addr_in == 7'h7e && quiet |=>
    {genreg_pointer_out[2:0], alu_status_word_out[4]} == $past(sys_wdata_in))
    else $error("row nibble write lost");
  gr_addr_a: assert property (!rst_in |=>
    gr_addr_out == {$past(genreg_pointer_out), $past(gr_col_in)}) else $error("gr address");
  real_addr_a: assert property (alu_status_word_out[0] && index_applies_in |=>
    mem_real_addr_out == ($past(mem_addr_in) | $past(index_in))) else $error("index missed");
  plain_addr_a: assert property (!(alu_status_word_out[0] && index_applies_in) |=>
    mem_real_addr_out == $past(mem_addr_in)) else $error("index wrongly applied");
  soft_clear_a: assert property (!quiet && !sys_wr_in && !arith_valid_in |=>
    genreg_pointer_out == 7'h00 && alu_status_word_out == 5'h00) else $error("soft reset");
  unmapped_rd_a: assert property (sys_rd_in && sys_addr_in < 7'h7d |=>
    !sys_hit_out && sys_rdata_out == 4'h0) else $error("unmapped read answered");
  compare_only_a: assert property (arith_valid_in && alu_status_word_out[3] |=>
    !arith_store_out) else $error("store under compare");
  store_pulse_a: assert property (!arith_valid_in |=> !arith_store_out)
    else $error("store without request");
  store_given_a: assert property (arith_valid_in && !alu_status_word_out[3] |=>
    arith_store_out) else $error("store missing");
  arith_flags_a: assert property (arith_valid_in && arith_dest_sys_in && quiet &&
    arith_dest_addr_in == 7'h7f && !alu_status_word_out[3] && !sys_wr_in |=>
    alu_status_word_out[3:0] == arith_result_out) else $error("result not in flags");
endmodule // grp_regs_props
bind grp_regs grp_regs_props u_props (.core_clk_in, .rst_in, .wdt_reset_in, .ce_reset_in,
  .sys_addr_in, .sys_wr_in, .sys_rd_in, .sys_wdata_in, .sys_rdata_out, .sys_hit_out,
  .gr_col_in, .mem_addr_in, .index_in, .index_applies_in, .gr_addr_out, .mem_real_addr_out,
  .arith_valid_in, .arith_dest_sys_in, .arith_dest_addr_in, .arith_result_out,
  .arith_store_out, .genreg_pointer_out, .alu_status_word_out);

// ### verification/test_grp_regs.sv
// self-checking bench for the pointer and status word block
`timescale 1ns/1ps
module test_grp_regs;
  logic core_clk_in, rst_in, wdt_reset_in, ce_reset_in, sys_wr_in, sys_rd_in, sys_hit_out;
  logic [6:0] sys_addr_in, arith_dest_addr_in, genreg_pointer_out;
  logic [3:0] sys_wdata_in, sys_rdata_out, gr_col_in, arith_gr_data_in, arith_mem_data_in;
  logic [3:0] arith_result_out, f, r, a;
  logic [10:0] mem_addr_in, index_in, gr_addr_out, mem_real_addr_out;
  logic index_applies_in, arith_valid_in, arith_dest_sys_in, arith_store_out, d;
  logic [1:0] arith_op_in;
  logic [4:0] alu_status_word_out;
  logic decimal_flag_out, compare_only_flag_out, carry_flag_out, zero_flag_out;
  logic index_enable_flag_out;
  int bad_count, checks_done;
  grp_regs u_dut (.core_clk_in, .rst_in, .wdt_reset_in, .ce_reset_in, .sys_addr_in, .sys_wr_in,
    .sys_rd_in, .sys_wdata_in, .sys_rdata_out, .sys_hit_out, .gr_col_in, .mem_addr_in,
    .index_in, .index_applies_in, .gr_addr_out, .mem_real_addr_out, .arith_valid_in,
    .arith_op_in, .arith_gr_data_in, .arith_mem_data_in, .arith_dest_sys_in,
    .arith_dest_addr_in, .arith_result_out, .arith_store_out, .genreg_pointer_out,
    .alu_status_word_out, .decimal_flag_out, .compare_only_flag_out, .carry_flag_out,
    .zero_flag_out, .index_enable_flag_out);
  // free-running 200 MHz clock
  initial begin
    core_clk_in = 1'b0;
    forever #2.5 core_clk_in = ~core_clk_in;
  end
  task automatic chk(input string nm, input logic [10:0] e, input logic [10:0] g);
    checks_done++;
    if (g !== e) begin
      bad_count++;
      $display("BAD %s expected %h seen %h", nm, e, g);
    end
  endtask
  // inputs move 1 ns after the edge, clear of sampling
  task automatic cyc();
    @(posedge core_clk_in);
    #1;
  endtask
  // a spare cycle after each strobe keeps drops and raises in separate steps
  task automatic wr(input logic [6:0] ad, input logic [3:0] dt);
    sys_addr_in = ad;
    sys_wdata_in = dt;
    sys_wr_in = 1'b1;
    cyc();
    sys_wr_in = 1'b0;
    cyc();
  endtask
  task automatic rd(input logic [6:0] ad, input logic [3:0] e, input logic h);
    sys_addr_in = ad;
    sys_rd_in = 1'b1;
    cyc();
    sys_rd_in = 1'b0;
    chk("rdata", e, sys_rdata_out);
    chk("hit", h, sys_hit_out);
    cyc();
  endtask
  // expected {carry, result}; decimal mode corrects by six
  function automatic logic [4:0] alu(input logic [1:0] op, input logic [3:0] x,
      input logic [3:0] y, input logic c, input logic dm);
    logic [4:0] s;
    s = op[1] ? {1'b0, x} - {1'b0, y} - {4'h0, op[0] & c} :
                {1'b0, x} + {1'b0, y} + {4'h0, op[0] & c};
    if (dm && !op[1] && s > 5'h09) s = {1'b1, s[3:0] + 4'h6};
    if (dm && op[1] && s[4]) s[3:0] = s[3:0] - 4'h6;
    return s;
  endfunction
  task automatic ar(input logic [1:0] op, input logic [3:0] x, input logic [3:0] y,
      input logic tf);
    logic [4:0] w;
    logic [4:0] s;
    w = alu_status_word_out;
    s = alu(op, x, y, w[2], w[4]);
    arith_op_in = op;
    arith_gr_data_in = x;
    arith_mem_data_in = y;
    arith_dest_sys_in = tf;
    arith_valid_in = 1'b1;
    cyc();
    arith_valid_in = 1'b0;
    chk("result", s[3:0], arith_result_out);
    chk("store", !w[3], arith_store_out);
    if (tf) chk("flag nibble", s[3:0], alu_status_word_out[3:0]);
    else chk("flags", {w[4:3], s[4], w[3] ? w[1] & (s[3:0] == 4'h0) : s[3:0] == 4'h0, w[0]},
      alu_status_word_out);
    cyc();
  endtask
  task automatic complete_run();
    $display("checks %0d mismatches %0d", checks_done, bad_count);
    if (bad_count == 0 && checks_done > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  // hang guard, far beyond the roughly 540 cycles the tests need
  initial begin
    #60000;
    bad_count++;
    complete_run();
  end
  initial begin
    {wdt_reset_in, ce_reset_in, sys_wr_in, sys_rd_in, index_applies_in, arith_valid_in} = '0;
    {sys_addr_in, sys_wdata_in, gr_col_in, mem_addr_in, index_in, arith_op_in} = '0;
    {arith_gr_data_in, arith_mem_data_in, arith_dest_sys_in} = '0;
    arith_dest_addr_in = grp_pkg::ADDR_FLAGS;
    rst_in = 1'b1;
    void'($urandom(57990));
    repeat (16) @(posedge core_clk_in);
    #1;
    rst_in = 1'b0;
    for (int i = 0; i < 3; i++) rd(7'h7d + 7'(i), 4'h0, 1'b1);
    $display("test reset values done");
    for (int i = 0; i < 20; i++) begin
      a = (i == 0) ? 4'hf : 4'($urandom);
      r = (i == 0) ? 4'hf : 4'($urandom);
      f = 4'($urandom);
      wr(grp_pkg::ADDR_PTR_BANK, a);
      wr(grp_pkg::ADDR_PTR_ROW, r);
      wr(grp_pkg::ADDR_FLAGS, f);
      chk("pointer", {a, r[3:1]}, genreg_pointer_out);
      chk("status", {r[0], f}, alu_status_word_out);
      chk("flag pins", {r[0], f}, {decimal_flag_out, compare_only_flag_out, carry_flag_out,
        zero_flag_out, index_enable_flag_out});
      rd(7'h7d, a, 1'b1);
      rd(7'h7e, r, 1'b1);
      rd(7'h7f, f, 1'b1);
      rd(7'(7'h60 + i), 4'h0, 1'b0);
      gr_col_in = 4'($urandom);
      mem_addr_in = 11'($urandom);
      index_in = 11'($urandom);
      index_applies_in = 1'($urandom);
      cyc();
      chk("gr_addr", {a, r[3:1], gr_col_in}, gr_addr_out);
      chk("real_addr", (f[0] & index_applies_in) ? mem_addr_in | index_in : mem_addr_in,
        mem_real_addr_out);
    end
    $display("test pointer and address done");
    for (int i = 0; i < 32; i++) begin
      wr(grp_pkg::ADDR_PTR_ROW, 4'($urandom));
      wr(grp_pkg::ADDR_FLAGS, 4'($urandom));
      d = alu_status_word_out[4];
      ar(2'(i), d ? 4'($urandom_range(9)) : 4'($urandom), d ? 4'($urandom_range(9)) :
        4'($urandom), 1'b0);
    end
    wr(grp_pkg::ADDR_PTR_ROW, 4'h0);
    wr(grp_pkg::ADDR_FLAGS, 4'h7);
    ar(grp_pkg::OP_ADD, 4'hf, 4'h1, 1'b1);
    wr(grp_pkg::ADDR_FLAGS, 4'hb);
    ar(grp_pkg::OP_ADD, 4'h0, 4'h0, 1'b0);
    $display("test arithmetic done");
    for (int k = 0; k < 2; k++) begin
      wr(grp_pkg::ADDR_PTR_BANK, 4'h9);
      wr(grp_pkg::ADDR_PTR_ROW, 4'hb);
      wr(grp_pkg::ADDR_FLAGS, 4'h5);
      wdt_reset_in = (k == 0);
      ce_reset_in = (k == 1);
      cyc();
      wdt_reset_in = 1'b0;
      ce_reset_in = 1'b0;
      chk("soft clear", {7'h00, 4'h0}, {genreg_pointer_out, alu_status_word_out[3:0]});
      chk("soft decimal", 1'b0, decimal_flag_out);
    end
    $display("test soft resets done");
    complete_run();
  end
endmodule // test_grp_regs
